// ==== src/ssa_averager.sv ====
// Segmented sequence capture and synchronous averager with register port.
// Assumes samples, trigger and range flags already synchronous to clk.
// Function
// - Sequential mode delivers each captured segment as its own record.
// - Averaging mode sums configured sweeps pointwise and delivers one waveform.
// - Alternate mode captures first channel on both slopes, averaged separately.
// - Alternate mode stores no second channel data; it may still trigger.
// - Trigger-rate strategy streams segments out, at most 1000 per refresh.
// - Points strategy streams segments out, at most 4000 per refresh.
// - Segment lasts ten time-per-division units.
// - Point count changes record length and sample interval, not timebase.
// - Standard uses programmed slope; alternate splits slopes into halves.
// - Results withheld until done; live sweep count refreshed each second.
// - Averaging stops when any channel hits target; per-channel counts reported.
// - Alternate stops when either slope hits target; report larger count.
// - Output points equal samples per trigger; count readable.
// - Rejection on discards sweeps with any out-of-range sample; alternate ignores second channel range.
// - Rejection off clamps overflow to max code, underflow to min.
// - Averaging record length limited by sample interval table.
// - Interpolated mode resamples linearly onto a uniform grid.
// - Random mode outputs samples at original positions.
// - Maximum trigger rate without misses is reported.
`include "ssa_map.svh"
module ssa_averager (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Register port.
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // Front end, already on clk.
    input wire logic trigPulse,
    input wire logic trigSlopeNeg,
    input wire logic trigFromCh2,
    input wire logic [7:0] ch1Sample,
    input wire logic [7:0] ch2Sample,
    input wire logic [1:0] ch1Range,
    input wire logic [1:0] ch2Range,
    input wire logic [7:0] sampleOffset,
    // Processing path output stream.
    output logic outValid,
    output logic outLast,
    output logic outChannel,
    output logic outHalf,
    output logic [15:0] outIndex,
    output logic [31:0] outData
);
    import ssa_pkg::*;

    localparam int PTS = 64;
    localparam int SWEEP_MAX = 65535;

    // Range flag bit 0 is underflow, bit 1 overflow.
    function automatic logic [7:0] clampSample(input logic [7:0] s, input logic [1:0] r);
        clampSample = r[1] ? `SSA_ADC_MAX : (r[0] ? `SSA_ADC_MIN : s);
    endfunction

    // Limit lookup on time per point in picoseconds.
    function automatic logic [31:0] recLimit(input logic [31:0] tpp, input logic alt);
        if (tpp == `SSA_TPP_500PS) begin
            recLimit = alt ? `SSA_LIM_50K : `SSA_LIM_100K;
        end else if (tpp == `SSA_TPP_1NS) begin
            recLimit = `SSA_LIM_50K;
        end else if (tpp == `SSA_TPP_2P5NS) begin
            recLimit = `SSA_LIM_100K;
        end else begin
            recLimit = `SSA_LIM_200K;
        end
    endfunction

    // Registers.
    logic [8:0] ctrl_q;
    logic [15:0] numSeg_q;
    logic [15:0] numPts_q;
    logic [31:0] tdivPs_q;
    ssa_state_t state_q;
    logic [15:0] ptr_q;
    logic [15:0] segCnt_q;
    logic [15:0] cnt1_q, cnt2_q, cntPos_q, cntNeg_q;
    logic [15:0] liveCnt_q;
    logic [31:0] secCnt_q;
    logic sweepBad_q;
    logic drain_q;
    logic [15:0] drainIdx_q;
    logic [1:0] drainSel_q;
    logic sampPrevV_q;
    logic [7:0] sampPrev_q;
    logic [7:0] offPrev_q;
    logic doneFlag_q;
    logic mergeGo_q;
    logic mergeNeg_q;
    // Accumulators are 24 bits: 255 times 65535 fits without wrapping.
    logic [23:0] acc1 [0:PTS-1];
    logic [23:0] acc2 [0:PTS-1];
    logic [23:0] accNeg [0:PTS-1];
    logic [23:0] staged1 [0:PTS-1];
    logic [23:0] staged2 [0:PTS-1];

    ssa_mode_t mode;
    logic altMode, maxPts, reject, interp, progSlope, startCmd, ackCmd;
    logic [31:0] segPs, tppPs, limit, effPts, rateHz;
    logic [15:0] segMax, target, pts;
    logic slopeOk, sweepNeg, capEnd, anyOut, badNow, modeChg;
    logic [7:0] s1, s2;

    assign mode = ssa_mode_t'(ctrl_q[1:0]);
    assign maxPts = ctrl_q[`SSA_CTRL_MAXPTS];
    assign altMode = ctrl_q[`SSA_CTRL_ALT];
    assign reject = ctrl_q[`SSA_CTRL_REJECT];
    assign interp = ctrl_q[`SSA_CTRL_INTERP];
    assign progSlope = ctrl_q[`SSA_CTRL_SLOPE];
    assign startCmd = regWr && regAddr == `SSA_REG_CTRL && regWdata[`SSA_CTRL_START];
    assign ackCmd = regWr && regAddr == `SSA_REG_CTRL && regWdata[`SSA_CTRL_ACK];
    assign modeChg = regWr && regAddr == `SSA_REG_CTRL && regWdata[1:0] != ctrl_q[1:0];

    // Segment length fixed by timebase; point count only splits it into points.
    assign segPs = tdivPs_q * `SSA_SEG_DIVS;
    assign tppPs = segPs / {16'h0000, (numPts_q == 16'h0000) ? 16'h0001 : numPts_q};
    assign limit = recLimit(tppPs, altMode);
    assign effPts = ({16'h0000, numPts_q} > limit) ? limit : {16'h0000, numPts_q};
    assign pts = (effPts > 32'(PTS)) ? 16'(PTS) : effPts[15:0];
    assign segMax = maxPts ? `SSA_MAX_SEG_PTS : `SSA_MAX_SEG_RATE;
    assign target = (mode == SSA_MODE_SEQ && numSeg_q > segMax) ? segMax : numSeg_q;
    // Rate bound: one segment plus fixed rearm overhead per trigger.
    assign rateHz = 32'd1000000000 / ((segPs / 32'd1000) + `SSA_TRIG_OVERHEAD + 32'd1);

    // Standard averaging takes only the programmed slope.
    assign slopeOk = altMode || (trigSlopeNeg == progSlope);
    assign sweepNeg = altMode && trigSlopeNeg;
    assign capEnd = state_q == SSA_ST_CAP && ptr_q == pts - 16'h0001;
    assign s1 = clampSample(ch1Sample, ch1Range);
    assign s2 = clampSample(ch2Sample, ch2Range);
    // Second channel range ignored in alternate mode since it is not stored.
    assign badNow = reject && (ch1Range != 2'b00 || (!altMode && ch2Range != 2'b00));
    assign anyOut = drain_q;

    // Capture sequencer. A mode change aborts the run in progress, but from idle a start written
    // together with a new mode arms at once, so software needs a single write.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= SSA_ST_IDLE;
        end else if (modeChg && !(state_q == SSA_ST_IDLE && startCmd)) begin
            state_q <= SSA_ST_IDLE;
        end else begin
            unique case (state_q)
                SSA_ST_IDLE: if (startCmd && regWdata[1:0] != 2'b00) state_q <= SSA_ST_ARM;
                // No trigger is taken while a segment still drains, so it is never overwritten.
                SSA_ST_ARM: begin
                    if (trigPulse && !drain_q && (mode == SSA_MODE_SEQ || slopeOk)) begin
                        state_q <= SSA_ST_CAP;
                    end
                end
                SSA_ST_CAP: if (capEnd) state_q <= SSA_ST_DONE;
                SSA_ST_DONE: state_q <= doneFlag_q ? SSA_ST_HOLD : SSA_ST_ARM;
                SSA_ST_HOLD: if (ackCmd && !drain_q) state_q <= SSA_ST_IDLE;
                default: state_q <= SSA_ST_IDLE;
            endcase
        end
    end

    // Point pointer and per-sweep artifact flag.
    // The flag restarts with every sweep, so one bad sweep never taints the next.
    always_ff @(posedge clk) begin
        if (!rst_n || state_q != SSA_ST_CAP) begin
            ptr_q <= 16'h0000;
            sweepBad_q <= 1'b0;
        end else begin
            ptr_q <= ptr_q + 16'h0001;
            sweepBad_q <= sweepBad_q | badNow;
        end
    end

    // Sweep counters; stop when any channel or slope hits the target.
    // A rejected sweep leaves every count alone, so it simply costs one more trigger.
    always_ff @(posedge clk) begin
        if (!rst_n || (state_q == SSA_ST_IDLE && startCmd)) begin
            {segCnt_q, cnt1_q, cnt2_q, cntPos_q, cntNeg_q} <= '0;
            doneFlag_q <= 1'b0;
        end else if (capEnd) begin
            if (mode == SSA_MODE_SEQ) begin
                segCnt_q <= segCnt_q + 16'h0001;
                doneFlag_q <= segCnt_q + 16'h0001 >= target;
            end else if (!(sweepBad_q | badNow)) begin
                if (altMode) begin
                    cntPos_q <= cntPos_q + {15'h0000, !sweepNeg};
                    cntNeg_q <= cntNeg_q + {15'h0000, sweepNeg};
                    doneFlag_q <= (sweepNeg ? cntNeg_q : cntPos_q) + 16'h0001 >= target;
                    cnt1_q <= ((sweepNeg ? cntNeg_q + 16'h0001 : cntNeg_q) >
                        (sweepNeg ? cntPos_q : cntPos_q + 16'h0001)) ?
                        (sweepNeg ? cntNeg_q + 16'h0001 : cntNeg_q) :
                        (sweepNeg ? cntPos_q : cntPos_q + 16'h0001);
                end else begin
                    cnt1_q <= cnt1_q + 16'h0001;
                    cnt2_q <= cnt2_q + 16'h0001;
                    doneFlag_q <= cnt1_q + 16'h0001 >= target;
                end
            end
        end
    end

    // Accumulate clamped samples; arrays cleared at run start.
    always_ff @(posedge clk) begin
        if (state_q == SSA_ST_IDLE && startCmd) begin
            for (int i = 0; i < PTS; i++) begin
                acc1[i] <= '0;
                acc2[i] <= '0;
                accNeg[i] <= '0;
            end
        end else if (mergeGo_q) begin
            // A clean staged sweep is added whole in the cycle after it ends.
            // Only the points of this run are added, since the rest of staging may be stale.
            for (int i = 0; i < PTS; i++) begin
                if (16'(i) < pts) begin
                    if (mergeNeg_q) begin
                        accNeg[i] <= accNeg[i] + staged1[i];
                    end else begin
                        acc1[i] <= acc1[i] + staged1[i];
                    end
                    if (!altMode) begin
                        acc2[i] <= acc2[i] + staged2[i];
                    end
                end
            end
        end else if (state_q == SSA_ST_CAP && mode == SSA_MODE_SEQ) begin
            acc1[ptr_q[5:0]] <= {16'h0000, s1};
            acc2[ptr_q[5:0]] <= {16'h0000, s2};
        end else if (state_q == SSA_ST_CAP && !reject) begin
            if (sweepNeg) begin
                accNeg[ptr_q[5:0]] <= accNeg[ptr_q[5:0]] + {16'h0000, s1};
            end else begin
                acc1[ptr_q[5:0]] <= acc1[ptr_q[5:0]] + {16'h0000, s1};
            end
            if (!altMode) begin
                acc2[ptr_q[5:0]] <= acc2[ptr_q[5:0]] + {16'h0000, s2};
            end
        end
    end

    // With rejection on, a sweep is staged and merged only if clean.
    always_ff @(posedge clk) begin
        if (state_q == SSA_ST_CAP && mode == SSA_MODE_AVG && reject) begin
            staged1[ptr_q[5:0]] <= {16'h0000, ch1Sample};
            staged2[ptr_q[5:0]] <= {16'h0000, altMode ? 8'h00 : ch2Sample};
        end
    end

    // Drain: segments stream after each capture, averages only at the end.
    // Storage holds one segment, so every segment drains before the next trigger;
    // the strategy bit only sets the segment cap.
    always_ff @(posedge clk) begin
        if (!rst_n || modeChg) begin
            drain_q <= 1'b0;
            drainIdx_q <= 16'h0000;
            drainSel_q <= 2'b00;
        end else if (state_q == SSA_ST_DONE &&
                (mode == SSA_MODE_SEQ || doneFlag_q)) begin
            drain_q <= 1'b1;
            drainIdx_q <= 16'h0000;
            drainSel_q <= 2'b00;
        end else if (drain_q) begin
            if (drainIdx_q == pts - 16'h0001) begin
                drainIdx_q <= 16'h0000;
                drainSel_q <= drainSel_q + 2'b01;
                drain_q <= drainSel_q == 2'b00;
            end else begin
                drainIdx_q <= drainIdx_q + 16'h0001;
            end
        end
    end

    // Merge of clean staged sweeps happens one cycle after capture end.
    always_ff @(posedge clk) begin
        mergeGo_q <= rst_n && capEnd && mode == SSA_MODE_AVG && reject && !(sweepBad_q | badNow);
    end
    always_ff @(posedge clk) begin
        mergeNeg_q <= rst_n && sweepNeg;
    end

    // Output stream; interpolation blends with previous sample by phase.
    logic [23:0] rawA, rawB;
    logic [7:0] interpVal;
    assign rawA = (drainSel_q == 2'b00) ? acc1[drainIdx_q[5:0]] :
        (altMode ? accNeg[drainIdx_q[5:0]] : acc2[drainIdx_q[5:0]]);
    assign rawB = {16'h0000, sampPrev_q};
    assign interpVal = 8'((({8'h00, rawB[7:0]} * {8'h00, 8'hff - offPrev_q}) +
        ({8'h00, rawA[7:0]} * {8'h00, offPrev_q})) >> 8);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {outValid, outLast, outChannel, outHalf} <= 4'h0;
            outIndex <= 16'h0000;
            outData <= 32'h0000_0000;
            sampPrev_q <= 8'h00;
            offPrev_q <= 8'h00;
            sampPrevV_q <= 1'b0;
        end else begin
            outValid <= anyOut;
            outLast <= anyOut && drainIdx_q == pts - 16'h0001;
            outChannel <= drainSel_q[0] && !altMode;
            outHalf <= drainSel_q[0] && altMode;
            outIndex <= drainIdx_q;
            sampPrev_q <= rawA[7:0];
            offPrev_q <= sampleOffset;
            sampPrevV_q <= anyOut;
            if (mode == SSA_MODE_SEQ && interp && sampPrevV_q) begin
                outData <= {24'h000000, interpVal};
            end else begin
                outData <= {8'h00, rawA};
            end
        end
    end

    // Software settings; staged merge shares acc only outside capture.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q <= 9'h000;
            numSeg_q <= 16'h0001;
            numPts_q <= 16'(PTS);
            tdivPs_q <= 32'd1000;
        end else if (regWr) begin
            unique case (regAddr)
                `SSA_REG_CTRL: ctrl_q <= {1'b0, regWdata[7:3], 1'b0, regWdata[1:0]};
                `SSA_REG_NSEG: numSeg_q <= regWdata[15:0];
                `SSA_REG_NPTS: numPts_q <= regWdata[15:0];
                `SSA_REG_TDIV: tdivPs_q <= regWdata;
                default: ;
            endcase
        end
    end

    // One-second live sweep count.
    always_ff @(posedge clk) begin
        if (!rst_n || secCnt_q == `SSA_ONE_SEC_CYC - 32'd1) begin
            secCnt_q <= 32'h0000_0000;
        end else begin
            secCnt_q <= secCnt_q + 32'd1;
        end
        if (!rst_n) begin
            liveCnt_q <= 16'h0000;
        end else if (secCnt_q == `SSA_ONE_SEC_CYC - 32'd1) begin
            liveCnt_q <= cnt1_q;
        end
    end

    // Read port, data one cycle after the strobe.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regRdata <= 32'h0000_0000;
        end else if (regRd) begin
            unique case (regAddr)
                `SSA_REG_CTRL: regRdata <= {23'h0, ctrl_q};
                `SSA_REG_NSEG: regRdata <= {16'h0, numSeg_q};
                `SSA_REG_NPTS: regRdata <= {16'h0, pts};
                `SSA_REG_TDIV: regRdata <= tdivPs_q;
                // Segment count in the upper half, done flag and sequencer state below.
                `SSA_REG_STAT: regRdata <= {segCnt_q, 8'h0, 3'h0, doneFlag_q,
                    1'b0, state_q};
                `SSA_REG_CNT1: regRdata <= {16'h0, cnt1_q};
                `SSA_REG_CNT2: regRdata <= {16'h0, cnt2_q};
                `SSA_REG_POS: regRdata <= {16'h0, cntPos_q};
                `SSA_REG_NEG: regRdata <= {16'h0, cntNeg_q};
                `SSA_REG_RATE: regRdata <= rateHz;
                `SSA_REG_TPP: regRdata <= tppPs;
                `SSA_REG_LIVE: regRdata <= {16'h0, liveCnt_q};
                default: regRdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// ==== src/ssa_map.svh ====
// Register map, field positions and constants for the sweep averager.
// Included by the package-using design file; definitions only.
`ifndef SSA_MAP_SVH
`define SSA_MAP_SVH
`define SSA_REG_CTRL 8'h00
`define SSA_REG_NSEG 8'h04
`define SSA_REG_NPTS 8'h08
`define SSA_REG_TDIV 8'h0c
`define SSA_REG_STAT 8'h10
`define SSA_REG_CNT1 8'h14
`define SSA_REG_CNT2 8'h18
`define SSA_REG_POS 8'h1c
`define SSA_REG_NEG 8'h20
`define SSA_REG_RATE 8'h24
`define SSA_REG_TPP 8'h28
`define SSA_REG_LIVE 8'h2c
`define SSA_CTRL_MODE_LSB 0
`define SSA_CTRL_START 2
`define SSA_CTRL_MAXPTS 3
`define SSA_CTRL_ALT 4
`define SSA_CTRL_REJECT 5
`define SSA_CTRL_INTERP 6
`define SSA_CTRL_SLOPE 7
`define SSA_CTRL_ACK 8
`define SSA_MAX_SEG_RATE 16'd1000
`define SSA_MAX_SEG_PTS 16'd4000
`define SSA_SEG_DIVS 32'd10
`define SSA_PTS_MEM 8'd64
`define SSA_ONE_SEC_CYC 32'd200000000
`define SSA_ADC_MAX 8'hff
`define SSA_ADC_MIN 8'h00
`define SSA_LIM_100K 32'd100000
`define SSA_LIM_50K 32'd50000
`define SSA_LIM_200K 32'd200000
`define SSA_TPP_500PS 32'd500
`define SSA_TPP_1NS 32'd1000
`define SSA_TPP_2P5NS 32'd2500
`define SSA_TRIG_OVERHEAD 32'd16
`define SSA_CLK_MHZ 32'd200
`endif

// ==== src/ssa_pkg.sv ====
// Types shared by the sweep averager.
// Assumes nothing beyond a SystemVerilog compiler.
package ssa_pkg;
    typedef enum logic [1:0] {
        SSA_MODE_OFF = 2'b00,
        SSA_MODE_SEQ = 2'b01,
        SSA_MODE_AVG = 2'b10
    } ssa_mode_t;
    typedef enum logic [2:0] {
        SSA_ST_IDLE = 3'b000,
        SSA_ST_ARM = 3'b001,
        SSA_ST_CAP = 3'b010,
        SSA_ST_DONE = 3'b011,
        SSA_ST_HOLD = 3'b100
    } ssa_state_t;
endpackage

// ==== sim/ssa_averager_asserts.sv ====
// Checker for the averager's read port and output stream.
// Assumes it is bound to ssa_averager and sees only its ports.
module ssa_averager_asserts (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Register port.
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdata,
    // Output stream.
    input wire logic outValid,
    input wire logic outLast,
    input wire logic outChannel,
    input wire logic outHalf,
    input wire logic [15:0] outIndex
);
    logic [31:0] ctrlQ;
    logic [15:0] nptsQ;
    // Shadow the mode and point count so the stream checks know the setup.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrlQ <= '0;
            nptsQ <= 16'h40;
        end else if (regWr && regAddr == 8'h00) begin
            ctrlQ <= regWdata;
        end else if (regWr && regAddr == 8'h08) begin
            nptsQ <= regWdata[15:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    reset_clears_a: assert property (disable iff (1'b0) !rst_n |=> !outValid && regRdata == '0)
        else $error("outputs not cleared by reset");
    rdata_hold_a: assert property (!regRd |=> $stable(regRdata))
        else $error("read data moved without a read");
    last_in_run_a: assert property (outLast |-> outValid)
        else $error("last flag outside a record");
    run_unbroken_a: assert property (outValid && !outLast |=> outValid)
        else $error("record broken before its last point");
    point_cap_a: assert property (outValid |-> outIndex < 16'h40)
        else $error("point index beyond storage");
    point_count_a: assert property (outValid && ctrlQ[1:0] == 2'h2 && !ctrlQ[4]
        |-> outIndex < nptsQ)
        else $error("averaged record longer than points per trigger");
    alt_ch1_only_a: assert property (outValid && ctrlQ[1:0] == 2'h2 && ctrlQ[4]
        |-> !outChannel)
        else $error("second channel data in alternate mode");
    std_one_half_a: assert property (outValid && !ctrlQ[4] |-> !outHalf)
        else $error("second half outside alternate mode");
endmodule

// ==== sim/ssa_frontend_model.sv ====
// Stand-in for the digitizer front end: trigger pulses and two sample channels.
// Assumes sweep() is called right after a rising edge of clk.
module ssa_frontend_model (
    // Clock.
    input wire logic clk,
    // Trigger towards the averager.
    output logic trigPulse,
    output logic trigSlopeNeg,
    output logic trigFromCh2,
    // Samples and range flags.
    output logic [7:0] ch1Sample,
    output logic [7:0] ch2Sample,
    output logic [1:0] ch1Range,
    output logic [1:0] ch2Range,
    output logic [7:0] sampleOffset
);
    logic [7:0] s1 [8];
    logic [7:0] s2 [8];
    logic [1:0] rg [8];
    logic busy = 1'b0;
    // Quiet lines at time zero.
    initial begin
        trigPulse = 1'b0;
        trigSlopeNeg = 1'b0;
        trigFromCh2 = 1'b0;
        ch1Range = 2'h0;
        ch2Range = 2'h0;
    end
    // Between sweeps the samples are noise, so a stale value never passes for data.
    always @(posedge clk) begin
        if (!busy) begin
            ch1Sample <= 8'($urandom);
            ch2Sample <= 8'($urandom);
            sampleOffset <= 8'($urandom);
        end
    end
    // One trigger, then one sample a cycle; a fault flags both channels mid-sweep.
    task automatic sweep(input logic neg, input int n, input logic [1:0] fault);
        busy = 1'b1;
        for (int i = 0; i < n; i++) begin
            s1[i] = 8'($urandom);
            s2[i] = 8'($urandom);
            rg[i] = (i == n / 2) ? fault : 2'h0;
        end
        trigPulse <= 1'b1;
        trigSlopeNeg <= neg;
        trigFromCh2 <= 1'($urandom);
        @(posedge clk);
        trigPulse <= 1'b0;
        for (int i = 0; i < n; i++) begin
            ch1Sample <= s1[i];
            ch2Sample <= s2[i];
            ch1Range <= rg[i];
            ch2Range <= rg[i];
            @(posedge clk);
        end
        ch1Range <= 2'h0;
        ch2Range <= 2'h0;
        busy = 1'b0;
    endtask
endmodule

// ==== sim/tb_ssa_averager.sv ====
// Self-checking bench for the sweep averager: averaging, alternate and sequence runs.
// Assumes the front-end model in its own file and the checker bound at the foot.
module tb_ssa_averager;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, regWr, regRd;
    logic [7:0] regAddr;
    logic [31:0] regWdata, regRdata, outData;
    logic trigPulse, trigSlopeNeg, trigFromCh2;
    logic [7:0] ch1Sample, ch2Sample, sampleOffset;
    logic [1:0] ch1Range, ch2Range;
    logic outValid, outLast, outChannel, outHalf;
    logic [15:0] outIndex;
    int mismatches = 0;
    int n_checks = 0;
    logic [33:0] gotQ [$];
    logic [33:0] expQ [$];
    logic [31:0] expS [2][2][8];
    ssa_averager dut (.clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
        .trigPulse, .trigSlopeNeg, .trigFromCh2, .ch1Sample, .ch2Sample, .ch1Range,
        .ch2Range, .sampleOffset, .outValid, .outLast, .outChannel, .outHalf,
        .outIndex, .outData);
    ssa_frontend_model fe (.clk, .trigPulse, .trigSlopeNeg, .trigFromCh2, .ch1Sample,
        .ch2Sample, .ch1Range, .ch2Range, .sampleOffset);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Collect each streamed point with its channel and half.
    always @(posedge clk) begin
        if (outValid === 1'b1) begin
            check("index", 34'(gotQ.size() % 8), {18'h0, outIndex});
            check("last", {33'h0, gotQ.size() % 8 == 7}, {33'h0, outLast});
            gotQ.push_back({outData, outChannel, outHalf});
        end
    end
    task automatic complete_run();
        $display("mismatches %0d checks %0d", mismatches, n_checks);
        if (mismatches == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [33:0] exp, input logic [33:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask
    // A gap cycle after each write keeps the strobe from being set twice at one edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        check(what, {2'b00, exp}, {2'b00, regRdata});
        @(posedge clk);
    endtask
    // Out-of-range samples become full-scale codes when not rejected.
    function automatic logic [7:0] clampv(input logic [7:0] s, input logic [1:0] r);
        return r[1] ? 8'hff : (r[0] ? 8'h00 : s);
    endfunction
    // One run: nt triggers of 8 points, then the whole stream compared in order.
    task automatic go(input logic [31:0] ctrl, input int nsw, input int nt,
        input logic [3:0] negs, input logic [7:0] faults);
        logic [1:0] f;
        logic [7:0] v;
        logic alt;
        alt = ctrl[4];
        gotQ.delete();
        expQ.delete();
        expS = '{default: '0};
        wr(8'h08, 32'h8);
        wr(8'h04, 32'(nsw));
        wr(8'h00, ctrl | 32'h4);
        repeat (4) @(posedge clk);
        for (int k = 0; k < nt; k++) begin
            f = faults[2*k +: 2];
            fe.sweep(negs[k], 8, f);
            for (int c = 0; c < 2; c++) begin
                for (int i = 0; i < 8; i++) begin
                    v = clampv(c ? fe.s2[i] : fe.s1[i], fe.rg[i]);
                    if (ctrl[1:0] == 2'h1) expQ.push_back({24'h0, v, c[0], 1'b0});
                    else if (!(ctrl[5] && f != 2'h0)) expS[c][alt && negs[k]][i] += v;
                end
            end
            repeat (30) @(posedge clk);
        end
        if (ctrl[1:0] == 2'h2) begin
            for (int c = 0; c < (alt ? 1 : 2); c++)
                for (int h = 0; h < (alt ? 2 : 1); h++)
                    for (int i = 0; i < 8; i++) expQ.push_back({expS[c][h][i], c[0], h[0]});
        end
        for (int w = 0; w < 200 && gotQ.size() < expQ.size(); w++) @(posedge clk);
        repeat (20) @(posedge clk);
        check("points", 34'(expQ.size()), 34'(gotQ.size()));
        foreach (expQ[j]) if (j < gotQ.size()) check("point", expQ[j], gotQ[j]);
    endtask
    initial begin
        rst_n = 1'b0;
        regAddr = 8'h0;
        regWdata = 32'h0;
        regWr = 1'b0;
        regRd = 1'b0;
        void'($urandom(32'hfeb01b51));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // Standard averaging with clamping: an underflow sweep, then an overflow one.
        go(32'h2, 3, 3, 4'h0, 8'h24);
        rdchk("sweeps ch1", 8'h14, 32'h3);
        wr(8'h00, 32'h102);
        // Rejection on: the overflow sweep is dropped, so a fourth trigger is needed.
        go(32'h22, 3, 4, 4'h0, 8'h08);
        rdchk("sweeps ch2", 8'h18, 32'h3);
        wr(8'h00, 32'h122);
        // Alternate averaging, slopes taking turns; the positive slope reaches 2 first.
        go(32'h12, 2, 3, 4'ha, 8'h00);
        rdchk("pos sweeps", 8'h1c, 32'h2);
        rdchk("neg sweeps", 8'h20, 32'h1);
        rdchk("larger count", 8'h14, 32'h2);
        wr(8'h00, 32'h112);
        // Two sequential segments, each delivered as its own record.
        go(32'h1, 2, 2, 4'h0, 8'h00);
        wr(8'h00, 32'h101);
        rdchk("unmapped", 8'hfc, 32'h0);
        wr(8'h0c, 32'd500);
        rdchk("points per trigger", 8'h08, 32'h8);
        rdchk("time per point", 8'h28, 32'd625);
        complete_run();
    end
    // The runs need under a thousand cycles; twenty thousand means a hang.
    initial begin
        #100000;
        mismatches++;
        complete_run();
    end
endmodule
bind ssa_averager ssa_averager_asserts chk (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .outValid(outValid), .outLast(outLast), .outChannel(outChannel), .outHalf(outHalf),
    .outIndex(outIndex));
